//--- sleep_wakeup_control.sv
// Sleep-mode wake-up sequencer: wake sources, oscillator-mode delays, resume target.
// Assumes the core decodes sleep and interrupt instructions into one-cycle pulses.
`timescale 1ns/1ps
module sleep_wakeup_control
    import swc_pkg::*;
#(
    parameter int HXT_SETTLE_CYCLES = swc_pkg::HXT_SETTLE_CYC,
    parameter int LXT_WAKE_CYCLES = swc_pkg::LXT_WAKE_CYC
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire swc_pkg::swc_cfg_s cfg,
    input wire logic [1:0] oscMode,
    input wire logic sleepInstr,
    input wire logic portChangeIn,
    input wire logic adcDoneIn,
    input wire logic adcClockTick,
    input wire logic extPinIn,
    input wire logic extFlagClear,
    output logic sleeping,
    output logic fetchStall,
    output logic wakeDone,
    output swc_pkg::swc_resume_s resume,
    output logic extPinIntFlag,
    output logic extPinVector
);
    import swc_pkg::*;

    logic rstSync1_reg, rstN;
    logic portSync1_reg, portSync2_reg, adcSync1_reg, adcSync2_reg, extSync1_reg, extSync2_reg;
    logic extPrev_reg;
    swc_state_e state_reg;
    logic [1:0] source_reg;
    logic [1:0] stage_reg;
    logic load, tick, expired;
    logic [CNT_W-1:0] loadValue;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release and input synchronisers
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rstSync1_reg <= 1'b0;
            rstN <= 1'b0;
        end else begin
            rstSync1_reg <= 1'b1;
            rstN <= rstSync1_reg;
        end
    end

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            portSync1_reg <= 1'b0;
            portSync2_reg <= 1'b0;
            adcSync1_reg <= 1'b0;
            adcSync2_reg <= 1'b0;
            extSync1_reg <= 1'b0;
            extSync2_reg <= 1'b0;
            extPrev_reg <= 1'b0;
        end else begin
            portSync1_reg <= portChangeIn;
            portSync2_reg <= portSync1_reg;
            adcSync1_reg <= adcDoneIn;
            adcSync2_reg <= adcSync1_reg;
            extSync1_reg <= extPinIn;
            extSync2_reg <= extSync1_reg;
            extPrev_reg <= extSync2_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wake source qualification: watchdog must be off for either source
    logic portWake, adcWake;
    assign portWake = portSync2_reg && cfg.portChangeWakeEnable && !cfg.watchdogEnable;
    assign adcWake = adcSync2_reg && cfg.adcDoneWakeEnable && !cfg.watchdogEnable;

    // Delay per stage: stage 0 main delay, stage 1 extra crystal clocks
    function automatic logic [CNT_W-1:0] mainDelay(input logic [1:0] mode, input logic [1:0] src);
        if (src == SRC_ADC) begin
            mainDelay = CNT_W'(ADC_WAKE_PERIODS);
        end else if (mode == OSC_HXT) begin
            mainDelay = CNT_W'(HXT_SETTLE_CYCLES);
        end else if (mode == OSC_LXT) begin
            mainDelay = CNT_W'(LXT_WAKE_CYCLES);
        end else begin
            mainDelay = CNT_W'(RC_WAKE_CLOCKS);
        end
    endfunction

    logic [1:0] wakeSrc;
    assign wakeSrc = portWake ? SRC_PORT : (adcWake ? SRC_ADC : SRC_NONE);

    always_comb begin
        load = 1'b0;
        loadValue = '0;
        if (state_reg == SWC_SLEEP && wakeSrc != SRC_NONE) begin
            load = 1'b1;
            loadValue = mainDelay(oscMode, wakeSrc);
        end else if (state_reg == SWC_WAIT && expired && stage_reg == 2'h0
                     && source_reg == SRC_PORT && oscMode == OSC_HXT) begin
            load = 1'b1;
            loadValue = CNT_W'(HXT_EXTRA_CLOCKS);
        end
    end

    // Converter wake counts converter clocks; otherwise core clocks
    assign tick = (source_reg == SRC_ADC) ? adcClockTick : 1'b1;

    swc_delay_counter uDelay (
        .mclk(mclk),
        .rstN(rstN),
        .load(load),
        .loadValue(loadValue),
        .tick(tick),
        .expired(expired)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Sleep state machine
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            state_reg <= SWC_RUN;
            source_reg <= SRC_NONE;
            stage_reg <= 2'h0;
        end else begin
            case (state_reg)
                SWC_RUN: begin
                    if (sleepInstr) begin
                        state_reg <= SWC_SLEEP;
                    end
                end
                SWC_SLEEP: begin
                    if (wakeSrc != SRC_NONE) begin
                        state_reg <= SWC_WAIT;
                        source_reg <= wakeSrc;
                        stage_reg <= 2'h0;
                    end
                end
                SWC_WAIT: begin
                    if (load) begin
                        stage_reg <= 2'h1;
                    end else if (expired) begin
                        state_reg <= SWC_RESUME;
                    end
                end
                SWC_RESUME: begin
                    state_reg <= SWC_RUN;
                end
                default: begin
                    state_reg <= SWC_RUN;
                end
            endcase
        end
    end

    assign sleeping = (state_reg == SWC_SLEEP);
    assign fetchStall = (state_reg == SWC_SLEEP) || (state_reg == SWC_WAIT);
    assign wakeDone = (state_reg == SWC_RESUME);

    ////////////////////////////////////////////////////////////////////////////
    // Resume target, registered at the end of the delay
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            resume <= '0;
        end else if (state_reg == SWC_WAIT && expired && !load) begin
            resume.vectorValid <= cfg.globalIntEnable;
            resume.vectorAddr <= (source_reg == SRC_ADC) ? VEC_ADC_DONE : VEC_PORT_CHANGE;
            resume.nextInstr <= !cfg.globalIntEnable;
        end else if (state_reg == SWC_RESUME) begin
            resume <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // External pin interrupt in normal mode; a new event beats a clear
    logic extEvent;
    assign extEvent = extSync2_reg && !extPrev_reg && cfg.extPinIntEnable
                      && state_reg == SWC_RUN;
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            extPinIntFlag <= 1'b0;
            extPinVector <= 1'b0;
        end else begin
            if (extEvent) begin
                extPinIntFlag <= 1'b1;
            end else if (extFlagClear) begin
                extPinIntFlag <= 1'b0;
            end
            // Vectoring only when enabled; with interrupts off execution just continues
            extPinVector <= extEvent && cfg.globalIntEnable;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    sequence wakeSeen_s;
        state_reg == SWC_SLEEP && wakeSrc != SRC_NONE;
    endsequence

    stall_in_wait_a: assert property (@(posedge mclk) disable iff (!rstN)
        state_reg == SWC_WAIT |-> fetchStall)
        else $error("fetch not stalled during wake delay");

    rc_delay_a: assert property (@(posedge mclk) disable iff (!rstN)
        (wakeSeen_s and oscMode == OSC_RC and wakeSrc == SRC_PORT) ##1 (oscMode == OSC_RC)[*8]
        |-> ##25 fetchStall ##1 (!fetchStall && wakeDone))
        else $error("rc wake delay not 32 clocks");

    watchdog_block_a: assert property (@(posedge mclk) disable iff (!rstN)
        state_reg == SWC_SLEEP && cfg.watchdogEnable |=> state_reg == SWC_SLEEP)
        else $error("woke with watchdog on");

    adc_gate_a: assert property (@(posedge mclk) disable iff (!rstN)
        state_reg == SWC_SLEEP && !cfg.adcDoneWakeEnable && !portWake |=> state_reg == SWC_SLEEP)
        else $error("woke without armed source");

    adc_load_a: assert property (@(posedge mclk) disable iff (!rstN)
        wakeSeen_s and wakeSrc == SRC_ADC |=> source_reg == SRC_ADC && state_reg == SWC_WAIT)
        else $error("adc wake not counted in converter clocks");

    vector_sel_a: assert property (@(posedge mclk) disable iff (!rstN)
        state_reg == SWC_RESUME && resume.vectorValid |->
        resume.vectorAddr == (source_reg == SRC_ADC ? VEC_ADC_DONE : VEC_PORT_CHANGE))
        else $error("wrong wake vector");

    next_instr_a: assert property (@(posedge mclk) disable iff (!rstN)
        state_reg == SWC_RESUME |-> resume.nextInstr != resume.vectorValid)
        else $error("resume target ambiguous");

    ext_flag_a: assert property (@(posedge mclk) disable iff (!rstN)
        extEvent |=> extPinIntFlag && (extPinVector == $past(cfg.globalIntEnable)))
        else $error("ext pin flag not set");

    hxt_long_a: assert property (@(posedge mclk) disable iff (!rstN)
        wakeSeen_s and oscMode == OSC_HXT |=> !wakeDone[*8])
        else $error("crystal wake too short");

    lxt_long_a: assert property (@(posedge mclk) disable iff (!rstN)
        wakeSeen_s and oscMode == OSC_LXT |=> fetchStall[*8])
        else $error("low crystal wake too short");
endmodule

//--- swc_pkg.sv
// Package for the sleep wake-up controller: modes, timing constants, carriers.
// Assumes a single 10 MHz core clock.
package swc_pkg;
    localparam int CLK_HZ = 10000000;
    localparam int CLK_PERIOD_NS = 100;
    // Oscillator modes
    localparam logic [1:0] OSC_RC = 2'h0;
    localparam logic [1:0] OSC_HXT = 2'h1;
    localparam logic [1:0] OSC_LXT = 2'h2;
    // Wake-up delays
    localparam int RC_WAKE_CLOCKS = 32;
    localparam int HXT_SETTLE_MS = 2;
    localparam int HXT_EXTRA_CLOCKS = 32;
    localparam int LXT_WAKE_MS = 500;
    localparam int ADC_WAKE_PERIODS = 15;
    localparam int HXT_SETTLE_CYC = (HXT_SETTLE_MS * (CLK_HZ / 1000));
    localparam int LXT_WAKE_CYC = (LXT_WAKE_MS * (CLK_HZ / 1000));
    localparam int CNT_W = 24;
    // Interrupt vectors
    localparam logic [7:0] VEC_PORT_CHANGE = 8'h06;
    localparam logic [7:0] VEC_ADC_DONE = 8'h0c;
    // Wake source codes
    localparam logic [1:0] SRC_NONE = 2'h0;
    localparam logic [1:0] SRC_PORT = 2'h1;
    localparam logic [1:0] SRC_ADC = 2'h2;

    typedef enum logic [3:0] {
        SWC_RUN = 4'h1,
        SWC_SLEEP = 4'h2,
        SWC_WAIT = 4'h4,
        SWC_RESUME = 4'h8
    } swc_state_e;

    typedef struct packed {
        logic portChangeWakeEnable;
        logic adcDoneWakeEnable;
        logic watchdogEnable;
        logic globalIntEnable;
        logic extPinIntEnable;
    } swc_cfg_s;

    typedef struct packed {
        logic vectorValid;
        logic [7:0] vectorAddr;
        logic nextInstr;
    } swc_resume_s;
endpackage

//--- swc_delay_counter.sv
// Down counter for the wake-up delay, loaded with a cycle count and ticked by an enable.
// Assumes the loader pulses load once per delay stage.
`timescale 1ns/1ps
module swc_delay_counter
    import swc_pkg::*;
(
    input wire logic mclk,
    input wire logic rstN,
    input wire logic load,
    input wire logic [swc_pkg::CNT_W-1:0] loadValue,
    input wire logic tick,
    output logic expired
);
    import swc_pkg::*;

    logic [CNT_W-1:0] count_reg;
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            count_reg <= '0;
        end else if (load) begin
            count_reg <= loadValue;
        end else if (tick && count_reg != '0) begin
            count_reg <= count_reg - 1'b1;
        end
    end
    // Plain zero flag: the loader reads it to chain stages, so it must not depend on load
    assign expired = (count_reg == '0);
endmodule

//--- sleep_wakeup_control_test.sv
// Self-checking bench for the sleep wake-up sequencer: wake delays, resume target, ext pin.
// Assumes the package constants and the shortened crystal counts set at the instance.
`timescale 1ns/1ps
module sleep_wakeup_control_test;
    import swc_pkg::*;
    localparam int HXT_SIM = 40;
    localparam int LXT_SIM = 60;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    swc_cfg_s cfg = '0;
    logic [1:0] oscMode = 2'h0;
    logic sleepInstr = 1'b0;
    logic portChangeIn = 1'b0;
    logic adcDoneIn = 1'b0;
    logic adcClockTick = 1'b0;
    logic extPinIn = 1'b0;
    logic extFlagClear = 1'b0;
    logic sleeping;
    logic fetchStall;
    logic wakeDone;
    swc_resume_s resume;
    logic extPinIntFlag;
    logic extPinVector;
    logic [1:0] tickDiv = 2'h0;
    int nFail = 0;
    int cmpCount = 0;

    always #50 mclk = ~mclk;

    // Converter clock runs free at a quarter of the core clock
    always @(negedge mclk) begin
        tickDiv <= tickDiv + 2'h1;
        adcClockTick <= (tickDiv == 2'h3);
    end

    sleep_wakeup_control #(.HXT_SETTLE_CYCLES(HXT_SIM), .LXT_WAKE_CYCLES(LXT_SIM)) uut (
        .mclk(mclk), .resetn(resetn), .cfg(cfg), .oscMode(oscMode),
        .sleepInstr(sleepInstr), .portChangeIn(portChangeIn), .adcDoneIn(adcDoneIn),
        .adcClockTick(adcClockTick), .extPinIn(extPinIn), .extFlagClear(extFlagClear),
        .sleeping(sleeping), .fetchStall(fetchStall), .wakeDone(wakeDone),
        .resume(resume), .extPinIntFlag(extPinIntFlag), .extPinVector(extPinVector)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic endSim();
        if (nFail == 0 && cmpCount > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        cmpCount++;
        if (got !== exp) begin
            nFail++;
            $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic doReset();
        @(negedge mclk);
        resetn = 1'b0;
        portChangeIn = 1'b0;
        adcDoneIn = 1'b0;
        repeat (10) @(negedge mclk);
        chk(fetchStall, 1'b0, "stall in reset");
        resetn = 1'b1;
        repeat (3) @(negedge mclk);
    endtask

    task automatic goSleep(input swc_cfg_s c, input logic [1:0] osc);
        cfg = c;
        oscMode = osc;
        // Port level settled low before sleep is the change reference
        portChangeIn = 1'b0;
        sleepInstr = 1'b1;
        @(negedge mclk);
        sleepInstr = 1'b0;
        chk(sleeping, 1'b1, "sleeping");
        chk(fetchStall, 1'b1, "stall on sleep");
        repeat (3) @(negedge mclk);
    endtask

    // Bounds count negedges from raising the source to the wakeDone cycle
    task automatic sleepWake(input logic [1:0] osc, input logic useAdc, input logic gie,
            input int lo, input int hi);
        int n;
        goSleep(swc_cfg_s'{!useAdc, useAdc, 1'b0, gie, 1'b0}, osc);
        if (useAdc) adcDoneIn = 1'b1;
        else portChangeIn = 1'b1;
        n = 0;
        while (wakeDone !== 1'b1 && n < 400) begin
            @(negedge mclk);
            n++;
            if (wakeDone !== 1'b1) chk(fetchStall, 1'b1, "stall held");
        end
        if (n >= 400) begin
            nFail++;
            endSim();
        end
        chk(8'(n >= lo && n <= hi), 8'h01, "wake delay");
        chk(resume.vectorValid, gie, "vector valid");
        if (gie) chk(resume.vectorAddr, useAdc ? 8'h0c : 8'h06, "vector");
        chk(resume.nextInstr, !gie, "next instr");
        portChangeIn = 1'b0;
        adcDoneIn = 1'b0;
        @(negedge mclk);
        chk(wakeDone, 1'b0, "done pulse");
        chk(fetchStall, 1'b0, "fetch resumed");
        chk(resume.vectorValid, 1'b0, "resume cleared");
    endtask

    // Wake attempt that must be refused; a reset ends the sleep
    task automatic noWake(input swc_cfg_s c, input logic usePort);
        goSleep(c, OSC_RC);
        if (usePort) portChangeIn = 1'b1;
        else adcDoneIn = 1'b1;
        repeat (100) begin
            @(negedge mclk);
            if (wakeDone !== 1'b0 || sleeping !== 1'b1) begin
                chk(sleeping, 1'b1, "left sleep on refused wake");
                chk(wakeDone, 1'b0, "refused wake");
                break;
            end
        end
        cmpCount++;
        doReset();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        doReset();
        sleepWake(OSC_RC, 1'b0, 1'b1, 2 + 33, 2 + 35);
        sleepWake(OSC_HXT, 1'b0, 1'b0, 2 + HXT_SIM + 34, 2 + HXT_SIM + 36);
        sleepWake(OSC_LXT, 1'b0, 1'b1, 2 + LXT_SIM + 1, 2 + LXT_SIM + 3);
        sleepWake(OSC_RC, 1'b1, 1'b1, 2 + 15 * 4 - 3, 2 + 15 * 4 + 5);
        sleepWake(OSC_LXT, 1'b1, 1'b0, 2 + 15 * 4 - 3, 2 + 15 * 4 + 5);
        noWake(swc_cfg_s'{1'b1, 1'b0, 1'b1, 1'b0, 1'b0}, 1'b1);
        noWake(swc_cfg_s'{1'b0, 1'b1, 1'b1, 1'b0, 1'b0}, 1'b0);
        noWake(swc_cfg_s'{1'b0, 1'b1, 1'b0, 1'b0, 1'b0}, 1'b1);
        noWake(swc_cfg_s'{1'b1, 1'b0, 1'b0, 1'b0, 1'b0}, 1'b0);
        // External pin in normal mode with interrupts off: flag only
        cfg = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
        extPinIn = 1'b1;
        repeat (6) begin
            @(negedge mclk);
            chk(extPinVector, 1'b0, "no ext vector");
        end
        chk(extPinIntFlag, 1'b1, "ext flag set");
        chk(fetchStall, 1'b0, "execution continues");
        extPinIn = 1'b0;
        extFlagClear = 1'b1;
        @(negedge mclk);
        extFlagClear = 1'b0;
        @(negedge mclk);
        chk(extPinIntFlag, 1'b0, "ext flag cleared");
        // Same event with interrupts on raises exactly one vector pulse
        cfg = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
        extPinIn = 1'b1;
        begin
            int hits;
            hits = 0;
            repeat (6) begin
                @(negedge mclk);
                if (extPinVector === 1'b1) hits++;
            end
            chk(8'(hits), 8'h01, "ext vector pulse");
        end
        extPinIn = 1'b0;
        repeat (3) @(negedge mclk);
        endSim();
    end
endmodule
